// File: design/sdram_pin_pkg.sv
// Package with widths, command codes, mode bit positions and timing constants
package sdram_pin_pkg;

  // ==========================================================
  // Geometry
  localparam int BANK_W = 3;
  localparam int ADDR_W = 16;
  localparam int DQ_W = 8;
  localparam int COL_BITS = 10;
  localparam int NUM_BANKS = 8;
  localparam int BYTE_BITS = 8;
  localparam int PAGE_BYTES = (2 ** COL_BITS) * DQ_W / BYTE_BITS;

  // ==========================================================
  // Address bit roles
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int MR1_TDQS_BIT = 11;
  localparam int MR1_ODT_LSB0 = 2;
  localparam int MR1_ODT_LSB1 = 6;
  localparam int MR1_ODT_LSB2 = 9;
  localparam int MR2_ASR_BIT = 6;
  localparam int MR2_SRT_BIT = 7;

  // ==========================================================
  // Reset values
  localparam logic [ADDR_W-1:0] MR_RESET = 16'h0000;
  localparam logic [NUM_BANKS-1:0] BANKS_IDLE = 8'h00;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int REFI_EXT_NS = 3900;
  localparam int REFI_EXT_CYC = (REFI_EXT_NS / CLK_PERIOD_NS > 0) ?
                                REFI_EXT_NS / CLK_PERIOD_NS : 1;
  localparam int BURST_FULL = 4;
  localparam int BURST_CHOP = 2;

  // ==========================================================
  // Commands: {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    CMD_MRS = 4'h0,
    CMD_REF = 4'h1,
    CMD_PRE = 4'h2,
    CMD_ACT = 4'h3,
    CMD_WR = 4'h4,
    CMD_RD = 4'h5,
    CMD_ZQ = 4'h6,
    CMD_NOP = 4'h7,
    CMD_DES = 4'h8
  } cmd_t;

  // Power states
  typedef enum logic [3:0] {
    PW_ACTIVE = 4'h1,
    PW_PRE_PD = 4'h2,
    PW_ACT_PD = 4'h4,
    PW_SELF_REF = 4'h8
  } pwr_t;

endpackage

// File: design/sdram_cmd_decode.sv
// Command decoder for the chip-select and strobe inputs
module sdram_cmd_decode
  import sdram_pin_pkg::*;
(
  // Command pins
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  // Decoded command
  output sdram_pin_pkg::cmd_t cmd
);

  always_comb begin
    if (cs_n) begin
      cmd = CMD_DES;
    end else begin
      case ({ras_n, cas_n, we_n})
        3'h0: cmd = CMD_MRS;
        3'h1: cmd = CMD_REF;
        3'h2: cmd = CMD_PRE;
        3'h3: cmd = CMD_ACT;
        3'h4: cmd = CMD_WR;
        3'h5: cmd = CMD_RD;
        3'h6: cmd = CMD_ZQ;
        default: cmd = CMD_NOP;
      endcase
    end
  end

endmodule

// File: design/sdram_skid_buf.sv
// Two-entry buffer with valid and ready on both sides
module sdram_skid_buf
  import sdram_pin_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Fill side
  input wire logic [DQ_W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [DQ_W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  logic [DQ_W-1:0] mem_q [2];
  logic [DQ_W-1:0] mem_d [2];
  logic [1:0] cnt_q, cnt_d;
  logic rd_q, rd_d;
  logic wr_q, wr_d;

  always_comb begin
    logic push;
    logic pop;
    push = 1'b0;
    pop = 1'b0;
    mem_d = mem_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    wr_d = wr_q;
    pop = out_ready && (cnt_q != 2'h0);
    // A full buffer still takes a word in the cycle it hands one on
    push = in_valid && ((cnt_q != 2'h2) || pop);
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      cnt_q <= 2'h0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      mem_q <= mem_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
    end
  end

  assign in_ready = (cnt_q != 2'h2) || out_ready;
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];

endmodule

// File: design/sdram_pin_iface.sv
// Command and pin interface of an eight-bank synchronous DRAM
// ==========================================================
module sdram_pin_iface
  import sdram_pin_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Command and address
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BANK_W-1:0] bank_addr,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic odt,
  // Write data path
  input wire logic [DQ_W-1:0] wr_data,
  input wire logic wr_mask,
  input wire logic wr_valid,
  // Read data path
  input wire logic [DQ_W-1:0] rd_data,
  input wire logic rd_valid,
  output logic rd_ready,
  // Data pins
  output logic [DQ_W-1:0] dq_out,
  output logic dq_oe,
  output logic dqs_out,
  output logic dqs_n_out,
  output logic dqs_oe,
  // Array side write port
  output logic [DQ_W-1:0] arr_wr_data,
  output logic arr_wr_en,
  input wire logic arr_ready,
  // Status
  output logic [NUM_BANKS-1:0] bank_open,
  output logic [3:0] pwr_state,
  output logic term_on,
  output logic tdqs_on,
  output logic [BANK_W-1:0] cur_bank,
  output logic [ADDR_W-1:0] cur_row,
  output logic [COL_BITS-1:0] cur_col,
  output logic auto_pre,
  output logic burst_chop,
  output logic [ADDR_W-1:0] mr1_val,
  output logic [ADDR_W-1:0] mr2_val,
  output logic ext_self_ref_ok,
  output logic [15:0] page_bytes
);

  cmd_t cmd;
  pwr_t pw_q, pw_d;
  logic [NUM_BANKS-1:0] open_q, open_d;
  logic [ADDR_W-1:0] mr_q [4];
  logic [ADDR_W-1:0] mr_d [4];
  logic [BANK_W-1:0] bank_q, bank_d;
  logic [ADDR_W-1:0] row_q, row_d;
  logic [COL_BITS-1:0] col_q, col_d;
  logic ap_q, ap_d;
  logic bc_q, bc_d;
  logic [2:0] beat_q, beat_d;
  logic wr_act_q, wr_act_d;
  logic rd_act_q, rd_act_d;
  logic term_q, term_d;
  logic [DQ_W-1:0] dq_q, dq_d;
  logic dq_oe_q, dq_oe_d;
  logic dqs_q, dqs_d;
  logic wr_push;
  logic dqs_n_q, dqs_n_d;
  logic tdqs_q, tdqs_d;
  logic esr_q, esr_d;
  logic [15:0] page_q;
  logic [DQ_W-1:0] buf_data;
  logic buf_valid;
  logic [DQ_W-1:0] arr_q;
  logic arr_en_q;
  logic cmd_live;

  // ==========================================================
  // Command decode
  sdram_cmd_decode u_dec (
    .cs_n(cs_n),
    .ras_n(ras_n),
    .cas_n(cas_n),
    .we_n(we_n),
    .cmd(cmd)
  );

  function automatic logic odt_enabled(input logic [ADDR_W-1:0] mr1);
    odt_enabled = mr1[MR1_ODT_LSB0] | mr1[MR1_ODT_LSB1] | mr1[MR1_ODT_LSB2];
  endfunction

  function automatic logic [2:0] burst_len(input logic chop);
    burst_len = chop ? 3'(BURST_CHOP) : 3'(BURST_FULL);
  endfunction

  // Commands only count with clock enable high in the active state, except a refresh with it low that enters self-refresh
  assign cmd_live = cke && (pw_q == PW_ACTIVE);

  // ==========================================================
  // Power state and bank tracking
  always_comb begin
    pw_d = pw_q;
    open_d = open_q;
    mr_d = mr_q;
    bank_d = bank_q;
    row_d = row_q;
    col_d = col_q;
    ap_d = ap_q;
    bc_d = bc_q;
    case (pw_q)
      PW_ACTIVE: begin
        if (!cke) begin
          if (open_q != BANKS_IDLE) begin
            pw_d = PW_ACT_PD;
          end else if (!cs_n && cmd == CMD_REF) begin
            pw_d = PW_SELF_REF;
          end else begin
            pw_d = PW_PRE_PD;
          end
        end
      end
      PW_PRE_PD, PW_ACT_PD: begin
        if (cke) begin
          pw_d = PW_ACTIVE;
        end
      end
      PW_SELF_REF: begin
        if (cke) begin
          pw_d = PW_ACTIVE;
        end
      end
      default: pw_d = PW_ACTIVE;
    endcase
    // Auto-precharge closes the bank at the last beat; an activate in the same cycle wins
    if ((wr_act_q || rd_act_q) && beat_q == 3'h1 && ap_q) begin
      open_d[bank_q] = 1'b0;
    end
    if (cmd_live) begin
      case (cmd)
        CMD_ACT: begin
          open_d[bank_addr] = 1'b1;
          bank_d = bank_addr;
          row_d = addr;
        end
        CMD_PRE: begin
          if (addr[AP_BIT]) begin
            open_d = BANKS_IDLE;
          end else begin
            open_d[bank_addr] = 1'b0;
          end
        end
        CMD_RD, CMD_WR: begin
          if (beat_q == 3'h0) begin
            bank_d = bank_addr;
            col_d = addr[COL_BITS-1:0];
            ap_d = addr[AP_BIT];
            bc_d = !addr[BC_BIT];
          end
        end
        CMD_MRS: begin
          if (bank_addr[2] == 1'b0) begin
            mr_d[bank_addr[1:0]] = addr;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pw_q <= PW_ACTIVE;
      open_q <= BANKS_IDLE;
      for (int i = 0; i < 4; i++) begin
        mr_q[i] <= MR_RESET;
      end
      bank_q <= '0;
      row_q <= '0;
      col_q <= '0;
      ap_q <= 1'b0;
      bc_q <= 1'b0;
    end else begin
      pw_q <= pw_d;
      open_q <= open_d;
      mr_q <= mr_d;
      bank_q <= bank_d;
      row_q <= row_d;
      col_q <= col_d;
      ap_q <= ap_d;
      bc_q <= bc_d;
    end
  end

  // ==========================================================
  // Burst, termination and data pins
  always_comb begin
    beat_d = beat_q;
    wr_act_d = wr_act_q;
    rd_act_d = rd_act_q;
    dq_d = dq_q;
    dq_oe_d = 1'b0;
    dqs_d = 1'b0;
    term_d = 1'b0;
    if (beat_q != 3'h0) begin
      beat_d = beat_q - 3'h1;
      if (beat_q == 3'h1) begin
        wr_act_d = 1'b0;
        rd_act_d = 1'b0;
      end
    end else if (cmd_live && (cmd == CMD_RD || cmd == CMD_WR)) begin
      beat_d = burst_len(!addr[BC_BIT]);
      rd_act_d = (cmd == CMD_RD);
      wr_act_d = (cmd == CMD_WR);
    end
    if (rd_act_q && rd_valid) begin
      dq_d = rd_data;
      dq_oe_d = 1'b1;
      dqs_d = ~dqs_q;
    end
    // Termination input stays live in power-down, not in self-refresh
    if (pw_q != PW_SELF_REF && odt && odt_enabled(mr_q[1]) && !rd_act_q) begin
      term_d = 1'b1;
    end
    dqs_n_d = ~dqs_d;
    tdqs_d = term_d && mr_d[1][MR1_TDQS_BIT];
    esr_d = !mr_d[2][MR2_ASR_BIT] && mr_d[2][MR2_SRT_BIT];
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      beat_q <= 3'h0;
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      dq_q <= '0;
      dq_oe_q <= 1'b0;
      dqs_q <= 1'b0;
      term_q <= 1'b0;
      dqs_n_q <= 1'b1;
      tdqs_q <= 1'b0;
      esr_q <= 1'b0;
      page_q <= 16'(PAGE_BYTES);
    end else begin
      beat_q <= beat_d;
      wr_act_q <= wr_act_d;
      rd_act_q <= rd_act_d;
      dq_q <= dq_d;
      dq_oe_q <= dq_oe_d;
      dqs_q <= dqs_d;
      term_q <= term_d;
      dqs_n_q <= dqs_n_d;
      tdqs_q <= tdqs_d;
      esr_q <= esr_d;
      page_q <= 16'(PAGE_BYTES);
    end
  end

  // ==========================================================
  // Write path through the two-entry buffer
  assign wr_push = wr_act_q && wr_valid &&
                   (mr_q[1][MR1_TDQS_BIT] || !wr_mask);

  sdram_skid_buf u_buf (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_data(wr_data),
    .in_valid(wr_push),
    .in_ready(),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(arr_ready)
  );

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      arr_q <= '0;
      arr_en_q <= 1'b0;
    end else begin
      arr_q <= buf_data;
      arr_en_q <= buf_valid && arr_ready;
    end
  end

  // ==========================================================
  // Outputs
  assign rd_ready = rd_act_q;
  assign dq_out = dq_q;
  assign dq_oe = dq_oe_q;
  assign dqs_out = dqs_q;
  assign dqs_n_out = dqs_n_q;
  assign dqs_oe = dq_oe_q;
  assign arr_wr_data = arr_q;
  assign arr_wr_en = arr_en_q;
  assign bank_open = open_q;
  assign pwr_state = pw_q;
  assign term_on = term_q;
  assign tdqs_on = tdqs_q;
  assign cur_bank = bank_q;
  assign cur_row = row_q;
  assign cur_col = col_q;
  assign auto_pre = ap_q;
  assign burst_chop = bc_q;
  assign mr1_val = mr_q[1];
  assign mr2_val = mr_q[2];
  assign ext_self_ref_ok = esr_q;
  assign page_bytes = page_q;

endmodule

// File: dv/sdram_pin_iface_chk.sv
// Concurrent checks on the pin interface ports
module sdram_pin_iface_chk
  import sdram_pin_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Command inputs
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BANK_W-1:0] bank_addr,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic odt,
  // Status outputs
  input wire logic [NUM_BANKS-1:0] bank_open,
  input wire logic [3:0] pwr_state,
  input wire logic term_on,
  input wire logic tdqs_on,
  input wire logic [ADDR_W-1:0] cur_row,
  input wire logic [ADDR_W-1:0] mr1_val,
  input wire logic [ADDR_W-1:0] mr2_val,
  input wire logic ext_self_ref_ok,
  input wire logic [15:0] page_bytes
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic go;
  logic [2:0] op;
  assign go = cke && pwr_state == 4'h1 && !cs_n;
  assign op = {ras_n, cas_n, we_n};
  // ==========================================================
  // Assertions
  mr_masked_a: assert property (cs_n |=> $stable(mr1_val))
    else $error("mode register changed while deselected");
  act_opens_a: assert property (go && op == 3'h3 |=>
    bank_open[$past(bank_addr)] && cur_row == $past(addr))
    else $error("activate did not open bank");
  pre_all_a: assert property (go && op == 3'h2 && addr[AP_BIT] |=> bank_open == 8'h00)
    else $error("precharge all left a bank open");
  mr1_write_a: assert property (go && op == 3'h0 && bank_addr == 3'h1 |=>
    mr1_val == $past(addr))
    else $error("mode register 1 not written");
  tdqs_mode_a: assert property (tdqs_on == (term_on && mr1_val[MR1_TDQS_BIT]))
    else $error("termination strobe mismatch");
  ext_sr_a: assert property (ext_self_ref_ok ==
    (!mr2_val[MR2_ASR_BIT] && mr2_val[MR2_SRT_BIT]))
    else $error("extended self-refresh flag mismatch");
  page_size_a: assert property (page_bytes == 16'h0400)
    else $error("page size wrong");
  pd_entry_a: assert property (!cke && cs_n && pwr_state == 4'h1 && bank_open == 8'h00
    |=> pwr_state == 4'h2)
    else $error("no precharge power-down");
  act_pd_a: assert property (!cke && pwr_state == 4'h1 && bank_open != 8'h00
    |=> pwr_state == 4'h4)
    else $error("no active power-down");
  pd_ignore_a: assert property (pwr_state != 4'h1 |=> $stable(bank_open))
    else $error("bank state changed in low power");
  term_off_a: assert property (!odt |=> !term_on)
    else $error("termination on without control");
  cover property (go && op == 3'h3);
  cover property (pwr_state == 4'h8);
  cover property (term_on);
endmodule
bind sdram_pin_iface sdram_pin_iface_chk sdram_pin_iface_chk_inst (.core_clk, .reset_n,
  .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_addr, .addr, .odt, .bank_open, .pwr_state,
  .term_on, .tdqs_on, .cur_row, .mr1_val, .mr2_val, .ext_self_ref_ok, .page_bytes);

// File: dv/sdram_array_model.sv
// Array-side model: read data source and stalling write sink
module sdram_array_model
  import sdram_pin_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Read source and write sink
  input wire logic rd_ready,
  output logic [DQ_W-1:0] rd_data,
  output logic rd_valid,
  output logic arr_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ph <= 2'h0;
      rd_data <= 8'h00;
    end else begin
      ph <= ph + 2'h1;
      rd_data <= rd_data + 8'h3B;
    end
  end
  // Stall one cycle in four
  assign arr_ready = ph != 2'h3;
  assign rd_valid = rd_ready && ph[0];
endmodule

// File: dv/sdram_pin_iface_tb.sv
// Self-checking bench for the pin interface
module sdram_pin_iface_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sdram_pin_pkg::*;
  logic core_clk, reset_n, cke, cs_n, ras_n, cas_n, we_n, odt, wr_mask, wr_valid;
  logic rd_valid, rd_ready, dq_oe, dqs_out, dqs_n_out, dqs_oe, arr_wr_en, arr_ready;
  logic term_on, tdqs_on, auto_pre, burst_chop, ext_self_ref_ok;
  logic [2:0] bank_addr, cur_bank;
  logic [15:0] addr, cur_row, mr1_val, mr2_val, page_bytes;
  logic [7:0] wr_data, rd_data, dq_out, arr_wr_data, bank_open, mopen;
  logic [3:0] pwr_state;
  logic [9:0] cur_col;
  logic [7:0] got_q[$], exp_q[$];
  logic [7:0] rexp_q[$], rgot_q[$];
  logic dqs_prev;
  logic [15:0] row;
  int bad_count, total_checks;
  sdram_pin_iface sdram_pin_iface_inst (.core_clk, .reset_n, .cke, .cs_n, .ras_n, .cas_n,
    .we_n, .bank_addr, .addr, .odt, .wr_data, .wr_mask, .wr_valid, .rd_data, .rd_valid,
    .rd_ready, .dq_out, .dq_oe, .dqs_out, .dqs_n_out, .dqs_oe, .arr_wr_data, .arr_wr_en,
    .arr_ready, .bank_open, .pwr_state, .term_on, .tdqs_on, .cur_bank, .cur_row, .cur_col,
    .auto_pre, .burst_chop, .mr1_val, .mr2_val, .ext_self_ref_ok, .page_bytes);
  sdram_array_model sdram_array_model_inst (.core_clk, .reset_n, .rd_ready, .rd_data,
    .rd_valid, .arr_ready);
  always #25 core_clk = ~core_clk;
  // Outputs are sampled mid-cycle, away from the edge that launches them
  always @(negedge core_clk) begin
    if (arr_wr_en === 1'b1) got_q.push_back(arr_wr_data);
    if (rd_valid === 1'b1 && rd_ready === 1'b1) rexp_q.push_back(rd_data);
    chk("dqsoe", {15'h0, dq_oe}, {15'h0, dqs_oe});
    if (dq_oe === 1'b1) begin
      rgot_q.push_back(dq_out);
      chk("dqs", {15'h0, ~dqs_prev}, {15'h0, dqs_out});
      chk("dqsn", {15'h0, ~dqs_out}, {15'h0, dqs_n_out});
    end
    dqs_prev = dqs_out;
  end
  // ==========================================================
  // Tasks
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask
  task automatic cmd(logic [3:0] c, logic [2:0] b, logic [15:0] a);
    {cs_n, ras_n, cas_n, we_n} = c;
    bank_addr = b;
    addr = a;
    cyc(1);
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    cyc(1);
  endtask
  task automatic wr(logic [2:0] b, logic [15:0] a, int n);
    logic [7:0] d;
    {cs_n, ras_n, cas_n, we_n} = 4'h4;
    bank_addr = b;
    addr = a;
    cyc(1);
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    repeat (n) begin
      d = 8'($urandom);
      wr_data = d;
      wr_mask = 1'($urandom);
      wr_valid = 1'b1;
      if (!wr_mask) exp_q.push_back(d);
      cyc(1);
    end
    wr_valid = 1'b0;
  endtask
  task automatic summarize;
    $display("checks %0d bad %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // Sequence
  initial begin
    core_clk = 0; reset_n = 0; cke = 1; {cs_n, ras_n, cas_n, we_n} = 4'hF;
    bank_addr = 0; addr = 0; odt = 0; wr_data = 0; wr_mask = 0; wr_valid = 0;
    mopen = 0; bad_count = 0; total_checks = 0; dqs_prev = 0;
    void'($urandom(62045));
    cyc(3);
    reset_n = 1;
    chk("pwr", 16'h1, pwr_state);
    chk("page", 16'h0400, page_bytes);
    cmd(4'h0, 3'h2, 16'h0080);
    cmd(4'h0, 3'h1, 16'h0004);
    chk("mr2", 16'h0080, mr2_val);
    chk("extsr", 16'h1, ext_self_ref_ok);
    odt = 1; cyc(2);
    chk("term", 16'h1, term_on);
    chk("tdqs", 16'h0, tdqs_on);
    odt = 0; cyc(2);
    chk("term", 16'h0, term_on);
    for (int i = 0; i < 8; i++) begin
      row = 16'($urandom);
      cmd((i == 3) ? 4'hB : 4'h3, 3'(i), row);
      if (i != 3) chk("row", row, cur_row);
      if (i != 3) mopen[i] = 1'b1;
      chk("open", mopen, bank_open);
    end
    cmd(4'h2, 3'h0, 16'h0000); mopen[0] = 0; cyc(1);
    chk("open", mopen, bank_open);
    wr(3'h1, 16'h1400, 4); cyc(2); mopen[1] = 0;
    chk("ap", 16'h1, auto_pre);
    chk("bc", 16'h0, burst_chop);
    chk("open", mopen, bank_open);
    wr(3'h2, 16'h0000, 2); cyc(2);
    chk("bc", 16'h1, burst_chop);
    chk("open", mopen, bank_open);
    for (int t = 0; t < 50 && got_q.size() < exp_q.size(); t++) cyc(1);
    chk("words", 16'(exp_q.size()), 16'(got_q.size()));
    foreach (exp_q[k]) if (k < got_q.size()) chk("word", exp_q[k], got_q[k]);
    cmd(4'h5, 3'h2, 16'h1155);
    chk("rdrdy", 16'h1, rd_ready);
    chk("bank", 16'h2, 16'(cur_bank));
    chk("col", 16'h0155, 16'(cur_col));
    chk("ap", 16'h0, 16'(auto_pre));
    cyc(8);
    chk("rdrdy", 16'h0, rd_ready);
    chk("rbeats", 16'(rexp_q.size()), 16'(rgot_q.size()));
    chk("rseen", 16'h1, 16'(rgot_q.size() != 0));
    foreach (rexp_q[k]) if (k < rgot_q.size()) chk("dq", rexp_q[k], rgot_q[k]);
    cmd(4'h2, 3'h0, 16'h0400); mopen = 0; cyc(1);
    chk("open", mopen, bank_open);
    repeat (2) begin
      cmd(4'h1, 3'h0, 16'h0000);
      cyc(REFI_EXT_CYC - 2);
      chk("pwr", 16'h1, pwr_state);
    end
    cke = 0; cyc(2);
    chk("pwr", 16'h2, pwr_state);
    cmd(4'h3, 3'h4, 16'h0001);
    chk("open", mopen, bank_open);
    cke = 1; cyc(2);
    chk("pwr", 16'h1, pwr_state);
    cmd(4'h3, 3'h5, 16'h0002); cke = 0; cyc(2);
    chk("pwr", 16'h4, pwr_state);
    cke = 1; cyc(2);
    cmd(4'h2, 3'h0, 16'h0400);
    {cs_n, ras_n, cas_n, we_n} = 4'h1; cke = 0; cyc(1);
    {cs_n, ras_n, cas_n, we_n} = 4'hF; cyc(2);
    chk("pwr", 16'h8, pwr_state);
    cke = 1; cyc(2);
    chk("pwr", 16'h1, pwr_state);
    cmd(4'h3, 3'h6, 16'h0003);
    reset_n = 0; cyc(1);
    chk("open", 16'h0, bank_open);
    chk("mr1", 16'h0, mr1_val);
    reset_n = 1; cyc(2);
    summarize();
  end
endmodule
